// ---- ddr4_timing_map.vh ----
`ifndef DDR4_TIMING_MAP_VH
`define DDR4_TIMING_MAP_VH

// command codes on the decoded command port
`define CMD_DES 3'h0
`define CMD_ACT 3'h1
`define CMD_PRE 3'h2
`define CMD_REF 3'h3
`define CMD_RD 3'h4
`define CMD_WR 3'h5
`define CMD_MRS 3'h6
`define CMD_ODT 3'h7

// mode register selects on the bank port
`define MR_SEL_ZERO 3'h0
`define MR_SEL_FOUR 3'h4
`define MR_SEL_SEVEN 3'h7

// field positions on the address port
`define MR0_BL_LO 0
`define MR0_BL_HI 1
`define MODE_FOUR_TOGGLE_BIT 11
`define MODE_FOUR_PRE_BIT 12

// burst field encodings and reset values
`define BL_FIXED_EIGHT 2'h0
`define BL_ON_THE_FLY 2'h1
`define BL_FIXED_CHOP 2'h2
`define MR0_BL_RESET 2'h0
`define MODE_FOUR_PRE_RESET 1'h0

// clock period and timing figures
`define CLK_PERIOD_PS 10000
`define PARITY_LATENCY 4'h5
`define PAR_ALERT_EXTRA_PS 6000
`define PAR_ALERT_PW_SLOW 8'h48
`define PAR_ALERT_PW_FAST 8'h50
`define PAR_ALERT_RSP_SLOW 7'h40
`define PAR_ALERT_RSP_FAST 7'h47
`define CRC_ALERT_MIN_PS 3000
`define CRC_ALERT_MAX_PS 13000
`define CRC_ALERT_PW 8'h06
`define WR_START_EIGHT 5'h04
`define WR_START_CHOP 5'h02
`define MODE_SEVEN_GAP 3'h5
`define TREFI_NORMAL_NS 7800
`define TREFI_HOT_NS 3900
`define TRFC1_NS 260
`define REFRESH_OWED_MAX 4'h8

// derived cycle counts: least times round up, longest round down, min one
`define CYC_UP(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_DN(ps) (((ps) / `CLK_PERIOD_PS) < 1 ? 1 : ((ps) / `CLK_PERIOD_PS))
`define PAR_ALERT_EXTRA_CYC `CYC_DN(`PAR_ALERT_EXTRA_PS)
`define CRC_ALERT_MIN_CYC `CYC_UP(`CRC_ALERT_MIN_PS)
`define CRC_ALERT_MAX_CYC `CYC_DN(`CRC_ALERT_MAX_PS)
`define TREFI_NORMAL_CYC `CYC_DN(`TREFI_NORMAL_NS * 1000)
`define TREFI_HOT_CYC `CYC_DN(`TREFI_HOT_NS * 1000)
`define TRFC1_CYC `CYC_UP(`TRFC1_NS * 1000)

`endif

// ---- alert_pulse_timer.v ----
module alert_pulse_timer #(
	parameter WIDTH = 8
) (
	input wire clk_sys_in,
	input wire rstn_in,
	input wire start_in,
	input wire [WIDTH-1:0] length_in,
	output wire active_out
);
	reg [WIDTH-1:0] remain;

	// a start while the pulse runs is ignored, the pulse is not stretched
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			remain <= {WIDTH{1'b0}};
		end else if (start_in && remain == {WIDTH{1'b0}}) begin
			remain <= length_in;
		end else if (remain != {WIDTH{1'b0}}) begin
			remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	assign active_out = (remain != {WIDTH{1'b0}});
endmodule

// ---- ddr4_alert_refresh_timing.v ----
`include "ddr4_timing_map.vh"

// Function
// RQ1: commands within parity latency window not executed
// RQ2: alert asserted by parity latency plus 6ns
// RQ3: parity alert held 72 or 80 cycles
// RQ4: controller sends deselects within 64/71 cycles
// RQ5: crc alert follows error within 3-13ns
// RQ6: crc alert pulse lasts 6 to 10 cycles
// RQ7: controller keeps geardown timings even clocks; the controller model never drives geardown
// RQ8: controller refreshes every 7.8us or 3.9us
// RQ9: eight-beat or on-the-fly chop: write at latency+4
// RQ10: fixed chop: internal write at latency+2
// RQ11: controller rounds write recovery clocks up; no write recovery is modelled
// RQ12: reads and sync odt need locked dll
// RQ13: crc with mask uses longer write recovery
// RQ14: power-down waits for running row operations
// RQ15: mode four bit 11 picks toggle preamble
// RQ16: mode four bit 12 picks preamble length
// RQ17: five clocks after mode seven write
// RQ18: controller sets reference midpoint before addressing; the controller model never drives addressing mode
// RQ19: controller converts ns timings rounding up; the controller model drives no ns-derived gaps
module ddr4_alert_refresh_timing #(
	parameter WPIPE_DEPTH = 32,
	parameter ROW_OP_CYCLES = 16
) (
	input wire clk_sys_in,
	input wire rstn_in,
	input wire [2:0] cmd_in,
	input wire [2:0] ba_in,
	input wire [13:0] addr_in,
	input wire par_in,
	input wire chop_otf_in,
	input wire persist_par_in,
	input wire par_err_clr_in,
	input wire fast_grade_in,
	input wire [4:0] write_latency_in,
	input wire crc_en_in,
	input wire mask_en_in,
	input wire crc_err_in,
	input wire dll_locked_in,
	input wire cke_in,
	input wire temp_hot_in,
	output reg alert_n_out,
	output reg cmd_exec_out,
	output reg [2:0] cmd_exec_code_out,
	output reg wr_start_out,
	output reg par_err_status_out,
	output reg rsp_late_out,
	output reg dll_cmd_err_out,
	output reg mr7_gap_err_out,
	output reg use_crc_mask_wr_out,
	output reg preamble_toggle_two_out,
	output reg preamble_two_out,
	output reg power_down_out,
	output reg refresh_late_out
);
	reg [3:0] blk_cnt;
	reg [3:0] par_dly;
	reg [1:0] burst_mode;
	reg [WPIPE_DEPTH-1:0] wr_pipe;
	reg [6:0] rsp_cnt;
	reg [2:0] mr7_cnt;
	reg [9:0] busy_cnt;
	reg [9:0] refi_cnt;
	reg [3:0] owed;
	reg [WPIPE_DEPTH-1:0] next_wr_pipe;
	wire par_active;
	wire crc_active;
	wire par_check;
	wire par_err;
	wire blocked;
	wire dll_block;
	wire accept;
	wire par_start;
	wire [7:0] par_pw;
	wire [6:0] rsp_limit;
	wire [9:0] refi_limit;
	wire [4:0] wr_delay;
	wire is_mrs;
	// full-width counts, cut to the ten-bit counters where used
	localparam [31:0] REFI_NORMAL_FULL = `TREFI_NORMAL_CYC;
	localparam [31:0] REFI_HOT_FULL = `TREFI_HOT_CYC;
	localparam [31:0] REF_BUSY_FULL = `TRFC1_CYC;
	localparam [31:0] ROW_BUSY_FULL = ROW_OP_CYCLES;

	// one bit set in a pipe of the given depth, zero if out of range
	function [WPIPE_DEPTH-1:0] pipe_bit;
		input [4:0] delay;
		integer i;
		begin
			pipe_bit = {WPIPE_DEPTH{1'b0}};
			for (i = 0; i < WPIPE_DEPTH; i = i + 1) begin
				if (delay != 5'h00 && i == delay - 1)
					pipe_bit[i] = 1'b1;
			end
		end
	endfunction

	// saturating one-step decrement used by the row busy counter
	function [9:0] dec_sat;
		input [9:0] value;
		begin
			dec_sat = (value == 10'h000) ? 10'h000 : value - 10'h001;
		end
	endfunction

	assign is_mrs = (cmd_in == `CMD_MRS);

	// a non-persistent device stops checking once an error is latched
	assign par_check = (cmd_in != `CMD_DES) &&
		!(par_err_status_out && !persist_par_in);
	assign par_err = par_check &&
		((^{cmd_in, ba_in, addr_in, chop_otf_in, par_in}) != 1'b0);

	// errant command and the following window are dropped
	assign blocked = par_err || (blk_cnt != 4'h0) || par_active; // RQ1

	// reads and sync odt are refused without a locked dll
	assign dll_block = !dll_locked_in &&
		(cmd_in == `CMD_RD || cmd_in == `CMD_ODT); // RQ12

	assign accept = (cmd_in != `CMD_DES) && !blocked && !dll_block;

	// alert pulse begins so the pin falls exactly one latency later
	assign par_start = (par_dly == 4'h1); // RQ2

	assign par_pw = fast_grade_in ? `PAR_ALERT_PW_FAST :
		`PAR_ALERT_PW_SLOW; // RQ3
	assign rsp_limit = fast_grade_in ? `PAR_ALERT_RSP_FAST :
		`PAR_ALERT_RSP_SLOW;
	assign refi_limit = temp_hot_in ? REFI_HOT_FULL[9:0] :
		REFI_NORMAL_FULL[9:0]; // RQ8

	// fixed chop starts the array write two clocks sooner
	assign wr_delay = write_latency_in + ((burst_mode == `BL_FIXED_CHOP) ?
		`WR_START_CHOP : `WR_START_EIGHT); // RQ9 RQ10

	alert_pulse_timer #(
		.WIDTH(8)
	) u_par_timer (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.start_in(par_start),
		.length_in(par_pw),
		.active_out(par_active)
	);

	// crc error raises the alert after one clock, inside 3..13 ns
	alert_pulse_timer #(
		.WIDTH(8)
	) u_crc_timer (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.start_in(crc_err_in), // RQ5
		.length_in(`CRC_ALERT_PW), // RQ6
		.active_out(crc_active)
	);

	always @* begin
		next_wr_pipe = {1'b0, wr_pipe[WPIPE_DEPTH-1:1]};
		if (accept && cmd_in == `CMD_WR)
			next_wr_pipe = next_wr_pipe | pipe_bit(wr_delay); // RQ9 RQ10
	end

	// parity window, alert lead counter and error status
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			blk_cnt <= 4'h0;
			par_dly <= 4'h0;
			par_err_status_out <= 1'b0;
		end else begin
			if (par_err && blk_cnt == 4'h0 && !par_active) begin
				blk_cnt <= `PARITY_LATENCY; // RQ1
				par_dly <= `PARITY_LATENCY - 4'h1; // RQ2
			end else begin
				if (blk_cnt != 4'h0)
					blk_cnt <= blk_cnt - 4'h1;
				if (par_dly != 4'h0)
					par_dly <= par_dly - 4'h1;
			end
			// a new error beats a clear in the same cycle
			if (par_err)
				par_err_status_out <= 1'b1;
			else if (par_err_clr_in)
				par_err_status_out <= 1'b0;
		end
	end

	// both alert sources share the one pin
	always @(posedge clk_sys_in) begin
		if (!rstn_in)
			alert_n_out <= 1'b1;
		else
			alert_n_out <= !(par_active || crc_active); // RQ3 RQ6
	end

	// controller must settle on deselects while a persistent alert runs
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			rsp_cnt <= 7'h00;
			rsp_late_out <= 1'b0;
		end else begin
			if (!par_active)
				rsp_cnt <= 7'h00;
			else if (rsp_cnt != 7'h7F)
				rsp_cnt <= rsp_cnt + 7'h01;
			rsp_late_out <= persist_par_in && par_active &&
				rsp_cnt >= rsp_limit && cmd_in != `CMD_DES; // RQ4
		end
	end

	// accepted command strobe, dll refusal flag and mode-seven gap flag
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			cmd_exec_out <= 1'b0;
			cmd_exec_code_out <= `CMD_DES;
			dll_cmd_err_out <= 1'b0;
			mr7_gap_err_out <= 1'b0;
		end else begin
			cmd_exec_out <= accept;
			if (accept)
				cmd_exec_code_out <= cmd_in;
			dll_cmd_err_out <= dll_block && !blocked; // RQ12
			mr7_gap_err_out <= (mr7_cnt != 3'h0) &&
				cmd_in != `CMD_DES && !is_mrs; // RQ17
		end
	end

	// mode register shadows and the mode-seven quiet gap
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			burst_mode <= `MR0_BL_RESET;
			preamble_toggle_two_out <= `MODE_FOUR_PRE_RESET;
			preamble_two_out <= `MODE_FOUR_PRE_RESET;
			mr7_cnt <= 3'h0;
		end else begin
			if (accept && is_mrs && ba_in == `MR_SEL_ZERO)
				burst_mode <= addr_in[`MR0_BL_HI:`MR0_BL_LO];
			// both supported grades accept the two-clock settings
			if (accept && is_mrs && ba_in == `MR_SEL_FOUR) begin
				preamble_toggle_two_out <=
					addr_in[`MODE_FOUR_TOGGLE_BIT]; // RQ15
				preamble_two_out <= addr_in[`MODE_FOUR_PRE_BIT]; // RQ16
			end
			if (accept && is_mrs && ba_in == `MR_SEL_SEVEN)
				mr7_cnt <= `MODE_SEVEN_GAP - 3'h1; // RQ17
			else if (mr7_cnt != 3'h0)
				mr7_cnt <= mr7_cnt - 3'h1;
		end
	end

	// internal write start pipe
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			wr_pipe <= {WPIPE_DEPTH{1'b0}};
			wr_start_out <= 1'b0;
		end else begin
			wr_pipe <= next_wr_pipe;
			wr_start_out <= wr_pipe[0];
		end
	end

	// power-down is held off until row operations complete
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			busy_cnt <= 10'h000;
			power_down_out <= 1'b0;
			use_crc_mask_wr_out <= 1'b0;
		end else begin
			if (accept && cmd_in == `CMD_REF)
				busy_cnt <= REF_BUSY_FULL[9:0]; // RQ14
			else if (accept && (cmd_in == `CMD_ACT || cmd_in == `CMD_PRE))
				busy_cnt <= ROW_BUSY_FULL[9:0]; // RQ14
			else
				busy_cnt <= dec_sat(busy_cnt);
			power_down_out <= !cke_in && busy_cnt == 10'h000 &&
				!(accept && cmd_in != `CMD_MRS); // RQ14
			use_crc_mask_wr_out <= crc_en_in && mask_en_in; // RQ13
		end
	end

	// refresh debt: one owed per interval, one paid per refresh
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			refi_cnt <= 10'h000;
			owed <= 4'h0;
			refresh_late_out <= 1'b0;
		end else begin
			if (refi_cnt >= refi_limit - 10'h001)
				refi_cnt <= 10'h000;
			else
				refi_cnt <= refi_cnt + 10'h001;
			if (refi_cnt >= refi_limit - 10'h001 &&
				!(accept && cmd_in == `CMD_REF)) begin
				if (owed != 4'hF)
					owed <= owed + 4'h1; // RQ8
			end else if (accept && cmd_in == `CMD_REF &&
				refi_cnt < refi_limit - 10'h001 && owed != 4'h0) begin
				owed <= owed - 4'h1;
			end
			refresh_late_out <= owed > `REFRESH_OWED_MAX;
		end
	end
endmodule

// ---- alert_timing_checker_assertions.sv ----
module alert_timing_checker (
	input wire clk_sys_in,
	input wire rstn_in,
	input wire [2:0] ba_in,
	input wire [13:0] addr_in,
	input wire [2:0] cmd_in,
	input wire fast_grade_in,
	input wire [4:0] write_latency_in,
	input wire crc_en_in,
	input wire crc_err_in,
	input wire alert_n_out,
	input wire cmd_exec_out,
	input wire [2:0] cmd_exec_code_out,
	input wire wr_start_out,
	input wire par_err_status_out,
	input wire preamble_toggle_two_out,
	input wire preamble_two_out,
	input wire power_down_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	logic [7:0] low_cnt;
	logic [5:0] wcnt;
	logic [2:0] ba_d;
	logic [13:0] addr_d;
	logic chop;
	wire mrs_done = cmd_exec_out && cmd_exec_code_out == 3'h6;
	wire wr_done = cmd_exec_out && cmd_exec_code_out == 3'h5;
	// one write in flight at a time; enough for the bench traffic
	always @(posedge clk_sys_in) begin
		ba_d <= ba_in;
		addr_d <= addr_in;
		low_cnt <= alert_n_out ? 8'h00 : low_cnt + 8'h01;
		if (!rstn_in)
			chop <= 1'b0;
		else if (mrs_done && ba_d == 3'h0)
			chop <= addr_d[1:0] == 2'h2;
		if (!rstn_in)
			wcnt <= 6'h00;
		else if (wr_done)
			wcnt <= {1'b0, write_latency_in} + (chop ? 6'h02 : 6'h04);
		else if (wcnt != 6'h00)
			wcnt <= wcnt - 6'h01;
	end
	a_exec_code_match: assert property (cmd_exec_out |->
		$past(cmd_in) != 3'h0 && cmd_exec_code_out == $past(cmd_in))
		else $error("executed code differs from command");
	a_par_alert_delay: assert property ($rose(par_err_status_out)
		|-> ##5 !alert_n_out) else $error("parity alert late");
	a_par_alert_width: assert property ($rose(alert_n_out) &&
		low_cnt > 8'h0A |-> low_cnt == (fast_grade_in ? 8'h50 : 8'h48))
		else $error("parity alert width wrong");
	a_crc_alert_delay: assert property (crc_en_in && crc_err_in &&
		alert_n_out |-> ##2 !alert_n_out) else $error("crc alert late");
	a_crc_alert_width: assert property ($rose(alert_n_out) &&
		low_cnt <= 8'h0A |-> low_cnt == 8'h06)
		else $error("crc alert width wrong");
	a_write_start_time: assert property (
		wr_start_out == (wcnt == 6'h01)) else $error("write start off");
	a_preamble_fields: assert property (mrs_done && ba_d == 3'h4 |=>
		preamble_two_out == $past(addr_d[12]) &&
		preamble_toggle_two_out == $past(addr_d[11]))
		else $error("preamble bits wrong");
	a_row_op_pd: assert property (cmd_exec_out &&
		cmd_exec_code_out == 3'h1 |-> !power_down_out [*8])
		else $error("power down during row operation");
	c_write: cover property (wr_start_out);
	c_parity: cover property ($rose(par_err_status_out));
	c_crc: cover property ($rose(alert_n_out) && low_cnt == 8'h06);
endmodule

bind ddr4_alert_refresh_timing alert_timing_checker i_chk (.*);

// ---- ddr4_ctrl_model.sv ----
module ddr4_ctrl_model (
	input wire alert_n_in,
	input wire dll_locked_in,
	input wire rude_in,
	input wire bad_par_in,
	input wire [2:0] req_cmd_in,
	input wire [2:0] req_ba_in,
	input wire [13:0] req_addr_in,
	output logic [2:0] cmd_out,
	output logic [2:0] ba_out,
	output logic [13:0] addr_out,
	output logic par_out,
	output logic chop_otf_out
);
	wire rd_like = req_cmd_in == 3'h4 || req_cmd_in == 3'h7;
	always_comb begin
		cmd_out = req_cmd_in;
		if (!alert_n_in && !rude_in)
			cmd_out = 3'h0;
		if (rd_like && !dll_locked_in && !rude_in)
			cmd_out = 3'h0;
		// geardown, addressing mode and ns-derived gaps are never driven
		ba_out = req_ba_in;
		// idle address lines wander so stale values never look valid
		addr_out = cmd_out == 3'h0 ? ~req_addr_in : req_addr_in;
		chop_otf_out = 1'b0;
		par_out = ^{cmd_out, ba_out, addr_out, chop_otf_out} ^ bad_par_in;
	end
endmodule

// ---- tb_ddr4_alert_refresh_timing.sv ----
module tb_ddr4_alert_refresh_timing;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [2:0] rq_c = 3'h0, rq_b = 3'h0;
	logic [13:0] rq_a = 14'h0000;
	logic bad = 0, rude = 0, par_err_clr_in = 0, fast_grade_in = 0;
	logic crc_en_in = 1, mask_en_in = 0, crc_err_in = 0;
	logic dll_locked_in = 1, cke_in = 1;
	logic [4:0] write_latency_in = 5'h05;
	logic persist_par_in = 1'b0, temp_hot_in = 1'b0;
	wire [2:0] cmd_in, ba_in, cmd_exec_code_out;
	wire [13:0] addr_in;
	wire par_in, chop_otf_in, alert_n_out, cmd_exec_out, wr_start_out;
	wire par_err_status_out, rsp_late_out, dll_cmd_err_out, mr7_gap_err_out;
	wire use_crc_mask_wr_out, preamble_toggle_two_out, preamble_two_out;
	wire power_down_out, refresh_late_out;
	int errors = 0, check_count = 0, cycles = 0, n, w;
	always #5 clk_sys_in = ~clk_sys_in;
	ddr4_alert_refresh_timing i_dut (.*);
	ddr4_ctrl_model i_ctrl (.alert_n_in(alert_n_out),
		.dll_locked_in(dll_locked_in), .rude_in(rude), .bad_par_in(bad),
		.req_cmd_in(rq_c), .req_ba_in(rq_b), .req_addr_in(rq_a),
		.cmd_out(cmd_in), .ba_out(ba_in), .addr_out(addr_in),
		.par_out(par_in), .chop_otf_out(chop_otf_in));
	task test_done;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			test_done;
		end
	end
	task cyc;
		@(posedge clk_sys_in);
		#1;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task send(input [2:0] c, input [2:0] b, input [13:0] a, input e);
		@(posedge clk_sys_in);
		rq_c <= c;
		rq_b <= b;
		rq_a <= a;
		bad <= e;
		@(posedge clk_sys_in);
		rq_c <= 3'h0;
		bad <= 1'b0;
		#1;
	endtask
	// counts cycles until alert drops, then how long it stays low
	task shape(input int start);
		n = start;
		while (alert_n_out !== 1'b0 && n < 50) begin
			cyc;
			n++;
		end
		w = 0;
		while (alert_n_out === 1'b0 && w < 300) begin
			cyc;
			w++;
		end
	endtask
	task t_exec_pd;
		@(posedge clk_sys_in);
		cke_in <= 1'b0;
		send(3'h1, 3'h1, 14'h0123, 1'b0);
		chk(cmd_exec_out, 1'b1);
		chk(cmd_exec_code_out, 3'h1);
		repeat (8) cyc;
		chk(power_down_out, 1'b0);
		repeat (20) cyc;
		chk(power_down_out, 1'b1);
		@(posedge clk_sys_in);
		cke_in <= 1'b1;
	endtask
	task t_parity(input logic g);
		@(posedge clk_sys_in);
		fast_grade_in <= g;
		send(3'h1, 3'h0, 14'h0010, 1'b1);
		send(3'h2, 3'h0, 14'h0000, 1'b0);
		chk(cmd_exec_out, 1'b0);
		chk(par_err_status_out, 1'b1);
		shape(2);
		chk(n, 5);
		chk(w, g ? 80 : 72);
		@(posedge clk_sys_in);
		par_err_clr_in <= 1'b1;
		@(posedge clk_sys_in);
		par_err_clr_in <= 1'b0;
		cyc;
		chk(par_err_status_out, 1'b0);
	endtask
	task t_crc;
		@(posedge clk_sys_in);
		crc_err_in <= 1'b1;
		@(posedge clk_sys_in);
		crc_err_in <= 1'b0;
		#1;
		shape(0);
		chk(n, 1);
		chk(w, 6);
	endtask
	task t_write(input logic ch);
		send(3'h6, 3'h0, ch ? 14'h0002 : 14'h0000, 1'b0);
		send(3'h5, 3'h0, 14'h0000, 1'b0);
		n = 0;
		while (wr_start_out !== 1'b1 && n < 60) begin
			cyc;
			n++;
		end
		chk(n, write_latency_in + (ch ? 2 : 4));
	endtask
	task t_dll;
		@(posedge clk_sys_in);
		dll_locked_in <= 1'b0;
		rude <= 1'b1;
		for (int c = 4; c < 8; c += 3) begin
			send(c[2:0], 3'h0, 14'h0000, 1'b0);
			chk(cmd_exec_out, 1'b0);
			chk(dll_cmd_err_out, 1'b1);
		end
		@(posedge clk_sys_in);
		dll_locked_in <= 1'b1;
		rude <= 1'b0;
		send(3'h4, 3'h0, 14'h0000, 1'b0);
		chk(cmd_exec_code_out, 3'h4);
	endtask
	task t_mr4;
		send(3'h6, 3'h4, 14'h1000, 1'b0);
		cyc;
		chk(preamble_two_out, 1'b1);
		chk(preamble_toggle_two_out, 1'b0);
		send(3'h6, 3'h4, 14'h0800, 1'b0);
		cyc;
		chk(preamble_two_out, 1'b0);
		chk(preamble_toggle_two_out, 1'b1);
		chk(use_crc_mask_wr_out, 1'b0);
		@(posedge clk_sys_in);
		mask_en_in <= 1'b1;
		repeat (2) cyc;
		chk(use_crc_mask_wr_out, 1'b1);
	endtask
	// persistent alert: non-deselects flagged only after the grace time
	task t_persist;
		@(posedge clk_sys_in);
		fast_grade_in <= 1'b0;
		persist_par_in <= 1'b1;
		rude <= 1'b1;
		send(3'h1, 3'h0, 14'h0010, 1'b1);
		repeat (66) cyc;
		send(3'h1, 3'h0, 14'h0000, 1'b0);
		chk(rsp_late_out, 1'b0);
		send(3'h1, 3'h0, 14'h0000, 1'b0);
		chk(rsp_late_out, 1'b1);
		shape(0);
		@(posedge clk_sys_in);
		par_err_clr_in <= 1'b1;
		persist_par_in <= 1'b0;
		rude <= 1'b0;
		@(posedge clk_sys_in);
		par_err_clr_in <= 1'b0;
	endtask
	task t_mr7;
		send(3'h6, 3'h7, 14'h0000, 1'b0);
		send(3'h1, 3'h0, 14'h0000, 1'b0);
		chk(mr7_gap_err_out, 1'b1);
		cyc;
		send(3'h1, 3'h0, 14'h0000, 1'b0);
		chk(mr7_gap_err_out, 1'b0);
	endtask
	// no refresh is sent, so the debt passes eight hot intervals
	task t_refresh;
		chk(refresh_late_out, 1'b0);
		@(posedge clk_sys_in);
		temp_hot_in <= 1'b1;
		n = 0;
		while (refresh_late_out !== 1'b1 && n < 3600) begin
			cyc;
			n++;
		end
		chk(n > 8 * 390 && n <= 9 * 390 + 2, 1'b1);
		send(3'h3, 3'h0, 14'h0000, 1'b0);
		cyc;
		chk(refresh_late_out, 1'b0);
		@(posedge clk_sys_in);
		temp_hot_in <= 1'b0;
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		repeat (2) cyc;
		chk(alert_n_out, 1'b1);
		t_exec_pd;
		t_parity(1'b0);
		t_parity(1'b1);
		t_crc;
		t_write(1'b0);
		t_write(1'b1);
		t_dll;
		t_mr4;
		t_persist;
		t_mr7;
		t_refresh;
		test_done;
	end
endmodule
